// ===== hw/led_sink_serial_and_diag.sv
// Control logic of a 16-channel LED current-sink driver: serial load path,
// greyscale PWM, staggered channel switching, open/short/thermal diagnostics.
// Assumes all pins are asynchronous to mclk and sampled here; analog comparators
// deliver levels. Software reaches control and status over AXI4-Lite.
`timescale 1ns/1ps
`include "led_sink_cfg.svh"

module led_sink_serial_and_diag
  import led_sink_pkg::*;
#(
   parameter int N_CH = `N_CHANNELS
) (
   input  wire logic                     mclk,
   input  wire logic                     resetn,
   input  wire led_sink_pkg::axil_req_t  axi_req,
   output led_sink_pkg::axil_rsp_t       axi_rsp,
   input  wire led_sink_pkg::pins_t      pins,
   output logic                          serial_out,
   output led_sink_pkg::od_pin_t         error_out_n,
   output logic [`N_CHANNELS-1:0]        sink_channel
);
   import led_sink_pkg::*;

   localparam int SAMPLE_CYC  = (`SAMPLE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int STAGGER_RAW = (`STAGGER_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int STAGGER_CYC = (STAGGER_RAW < 1) ? 1 : STAGGER_RAW;
   localparam int HIST_DEPTH  = N_CH * STAGGER_CYC;
   localparam int GSW         = `GS_BITS;
   localparam int DCW         = `DC_BITS;

   // Two-flop synchroniser; stage one is read only by stage two
   logic [`SYNC_BITS-1:0] sync1_q;
   logic [`SYNC_BITS-1:0] sync2_q;
   pins_t                 p;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
      end
   end
   assign p = pins_t'(sync2_q);

   // Edge detection on synchronised levels
   logic sclk_d_q;
   logic latch_d_q;
   logic gclk_d_q;
   logic od_d_q;
   logic sclk_rise;
   logic latch_rise;
   logic gclk_rise;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sclk_d_q  <= 1'b0;
         latch_d_q <= 1'b0;
         gclk_d_q  <= 1'b0;
         od_d_q    <= 1'b0;
      end else begin
         sclk_d_q  <= p.shift_clock;
         latch_d_q <= p.latch_strobe;
         gclk_d_q  <= p.pwm_count_clock;
         od_d_q    <= p.output_disable;
      end
   end
   assign sclk_rise  = p.shift_clock & ~sclk_d_q;
   assign latch_rise = p.latch_strobe & ~latch_d_q;
   assign gclk_rise  = p.pwm_count_clock & ~gclk_d_q;

   // Control register
   logic [7:0] ctrl_q;
   logic       disable_all;
   assign disable_all = p.output_disable | ctrl_q[`CTRL_SW_DISABLE];

   // Diagnostic flags
   logic [N_CH-1:0] open_q;
   logic [N_CH-1:0] short_q;
   logic            terr_q;
   logic            twarn_q;

   // Shift register and data registers
   logic [`SR_LEN_GS-1:0] sr_q;
   logic [N_CH*GSW-1:0]   gs_q;
   logic [N_CH*DCW-1:0]   dc_q;
   logic                  sout_q;
   logic [`SR_LEN_GS-1:0] status_packet;

   assign status_packet = {open_q, terr_q, twarn_q, 6'h00, dc_q,
                           40'h00_0000_0000, open_q, short_q};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sr_q <= '0;
      end else if (latch_rise && !p.mode_dc) begin
         sr_q <= status_packet;
      end else if (sclk_rise) begin
         sr_q <= {sr_q[`SR_LEN_GS-2:0], p.serial_in};
      end
   end

   // Output updated on the same edge as the shift, with the bit that moves to the end of the active length
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sout_q <= 1'b0;
      end else if (latch_rise && !p.mode_dc) begin
         // Latch wins over a shift in the same cycle, as in the register
         sout_q <= status_packet[`SID_OPEN_HI];
      end else if (sclk_rise) begin
         sout_q <= p.mode_dc ? sr_q[`SR_LEN_DC-2] : sr_q[`SR_LEN_GS-2];
      end
   end
   assign serial_out = sout_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         gs_q <= '0;
         dc_q <= '0;
      end else if (latch_rise) begin
         if (p.mode_dc) begin
            dc_q <= sr_q[`SR_LEN_DC-1:0];
         end else begin
            gs_q <= sr_q;
         end
      end
   end

   // Greyscale PWM counter; it saturates so a late disable still ends the cycle cleanly
   logic [GSW-1:0]  cnt_q;
   logic [GSW-1:0]  cnt_next;
   logic [N_CH-1:0] raw_on_q;

   assign cnt_next = cnt_q + 1'b1;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
      end else if (disable_all) begin
         cnt_q <= '0;
      end else if (gclk_rise && cnt_q != {GSW{1'b1}}) begin
         cnt_q <= cnt_next;
      end
   end

   // Per-channel switching, staggering and open/short sampling
   logic [N_CH-1:0] hist_q [HIST_DEPTH];
   logic [N_CH-1:0] ch_on;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int k = 0; k < HIST_DEPTH; k++) begin
            hist_q[k] <= '0;
         end
      end else begin
         hist_q[0] <= raw_on_q;
         for (int k = 1; k < HIST_DEPTH; k++) begin
            hist_q[k] <= hist_q[k-1];
         end
      end
   end

   genvar i;
   generate
      for (i = 0; i < N_CH; i++) begin : g_ch
         logic [GSW-1:0] gs_val;
         logic [4:0]     age_q;
         assign gs_val = gs_q[i*GSW +: GSW];

         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               raw_on_q[i] <= 1'b0;
            end else if (disable_all) begin
               raw_on_q[i] <= 1'b0;
            end else if (gclk_rise && cnt_q != {GSW{1'b1}}) begin
               if (gs_val == cnt_next) begin
                  raw_on_q[i] <= 1'b0;
               end else if (cnt_q == '0) begin
                  raw_on_q[i] <= (gs_val != '0);
               end
            end
         end

         // Same delay on both edges keeps the on-time
         assign ch_on[i] = hist_q[i*STAGGER_CYC][i] & ~disable_all;

         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               age_q <= '0;
            end else if (!ch_on[i]) begin
               age_q <= '0;
            end else if (age_q != 5'(SAMPLE_CYC)) begin
               age_q <= age_q + 5'h01;
            end
         end

         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               open_q[i]  <= 1'b0;
               short_q[i] <= 1'b0;
            end else if (ctrl_q[`CTRL_DET_EN] && ch_on[i] && age_q == 5'(SAMPLE_CYC - 1)) begin
               open_q[i]  <= p.open_cmp[i];
               short_q[i] <= p.short_cmp[i];
            end
         end
      end
   endgenerate

   assign sink_channel = ch_on;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         terr_q  <= 1'b0;
         twarn_q <= 1'b0;
      end else begin
         terr_q  <= p.over_temp;
         twarn_q <= p.warn_temp;
      end
   end

   // Open-drain error: short flags never contribute
   logic err_q;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         err_q <= 1'b0;
      end else begin
         err_q <= terr_q
                | ((|open_q) & ~p.output_disable)
                | (twarn_q & p.output_disable & p.mode_dc);
      end
   end
   assign error_out_n.o  = 1'b0;
   assign error_out_n.oe = err_q;

   // AXI4-Lite slave: one write and one read in flight
   logic                 aw_held_q;
   logic                 w_held_q;
   logic [`AXI_AW-1:0]   awaddr_q;
   logic [`AXI_DW-1:0]   wdata_q;
   logic [`AXI_DW/8-1:0] wstrb_q;
   logic                 bvalid_q;
   logic [1:0]           bresp_q;
   logic                 rvalid_q;
   logic [`AXI_DW-1:0]   rdata_q;
   logic [1:0]           rresp_q;
   logic                 aw_take;
   logic                 w_take;
   logic                 do_write;

   assign axi_rsp.awready = ~aw_held_q & ~bvalid_q;
   assign axi_rsp.wready  = ~w_held_q & ~bvalid_q;
   assign axi_rsp.arready = ~rvalid_q;
   assign axi_rsp.bvalid  = bvalid_q;
   assign axi_rsp.bresp   = bresp_q;
   assign axi_rsp.rvalid  = rvalid_q;
   assign axi_rsp.rdata   = rdata_q;
   assign axi_rsp.rresp   = rresp_q;

   assign aw_take  = axi_req.awvalid & axi_rsp.awready;
   assign w_take   = axi_req.wvalid & axi_rsp.wready;
   assign do_write = aw_held_q & w_held_q & ~bvalid_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         if (aw_take) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= axi_req.awaddr;
         end else if (do_write) begin
            aw_held_q <= 1'b0;
         end
         if (w_take) begin
            w_held_q <= 1'b1;
            wdata_q  <= axi_req.wdata;
            wstrb_q  <= axi_req.wstrb;
         end else if (do_write) begin
            w_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q   <= `CTRL_RESET;
         bvalid_q <= 1'b0;
         bresp_q  <= `RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (awaddr_q == `REG_CTRL) ? `RESP_OKAY : `RESP_DECERR;
         if (awaddr_q == `REG_CTRL && wstrb_q[0]) begin
            ctrl_q <= {6'h00, wdata_q[1:0]};
         end
      end else if (bvalid_q && axi_req.bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= `RESP_OKAY;
      end else if (axi_req.arvalid && axi_rsp.arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= `RESP_OKAY;
         unique case (axi_req.araddr)
            `REG_CTRL:  rdata_q <= {24'h00_0000, ctrl_q};
            `REG_DIAG:  rdata_q <= {short_q, open_q};
            `REG_STATE: rdata_q <= {12'h000, err_q, p.mode_dc, twarn_q, terr_q, 4'h0, cnt_q};
            default: begin
               rdata_q <= '0;
               rresp_q <= `RESP_DECERR;
            end
         endcase
      end else if (rvalid_q && axi_req.rready) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule

// ===== hw/led_sink_cfg.svh
// Constants of the LED current-sink control block: timing, bus map, field positions.
// Assumes a 20 MHz system clock; included by the package and the design.
`ifndef LED_SINK_CFG_SVH
`define LED_SINK_CFG_SVH

`define CLK_PERIOD_NS    50
`define SAMPLE_DELAY_NS  1000
`define STAGGER_STEP_NS  30
`define N_CHANNELS       16
`define GS_BITS          12
`define DC_BITS          6
`define SR_LEN_GS        192
`define SR_LEN_DC        96
`define SYNC_BITS        40

`define AXI_AW           8
`define AXI_DW           32
`define REG_CTRL         8'h00
`define REG_DIAG         8'h04
`define REG_STATE        8'h08
`define CTRL_RESET       8'h01
`define CTRL_DET_EN      0
`define CTRL_SW_DISABLE  1
`define RESP_OKAY        2'h0
`define RESP_DECERR      2'h3

`define SID_OPEN_HI      191
`define SID_TEF          175
`define SID_TWF          174
`define SID_DC_HI        167
`define SID_DC_LO        72

`endif

// ===== hw/led_sink_pkg.sv
// Types shared by the LED current-sink control block and its bench.
// Assumes led_sink_cfg.svh is on the include path.
`include "led_sink_cfg.svh"

package led_sink_pkg;

   typedef struct packed {
      logic                  awvalid;
      logic [`AXI_AW-1:0]    awaddr;
      logic                  wvalid;
      logic [`AXI_DW-1:0]    wdata;
      logic [`AXI_DW/8-1:0]  wstrb;
      logic                  bready;
      logic                  arvalid;
      logic [`AXI_AW-1:0]    araddr;
      logic                  rready;
   } axil_req_t;

   typedef struct packed {
      logic                  awready;
      logic                  wready;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [`AXI_DW-1:0]    rdata;
      logic [1:0]            rresp;
   } axil_rsp_t;

   // Pins arriving from outside the mclk domain
   typedef struct packed {
      logic                     shift_clock;
      logic                     serial_in;
      logic                     latch_strobe;
      logic                     mode_dc;
      logic                     output_disable;
      logic                     pwm_count_clock;
      logic                     over_temp;
      logic                     warn_temp;
      logic [`N_CHANNELS-1:0]   open_cmp;
      logic [`N_CHANNELS-1:0]   short_cmp;
   } pins_t;

   typedef struct packed {
      logic o;
      logic oe;
   } od_pin_t;

endpackage

// ===== tb/led_sink_sva.sv
// Concurrent checks on the LED sink control block's ports.
// Assumes binding to the top module; pins are asynchronous and pass a 2-FF synchroniser.
`timescale 1ns/1ps
`include "led_sink_cfg.svh"

module led_sink_sva
   import led_sink_pkg::*;
#(
   parameter int N_CH = `N_CHANNELS
) (
   input wire logic                     mclk,
   input wire logic                     resetn,
   input wire led_sink_pkg::axil_req_t  axi_req,
   input wire led_sink_pkg::axil_rsp_t  axi_rsp,
   input wire led_sink_pkg::pins_t      pins,
   input wire logic                     serial_out,
   input wire led_sink_pkg::od_pin_t    error_out_n,
   input wire logic [`N_CHANNELS-1:0]   sink_channel
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);

   od_low_a: assert property (error_out_n.o == 1'b0)
      else $error("error pin driven high");
   dis_off_a: assert property (pins.output_disable [*5] |-> sink_channel == '0)
      else $error("channel on while disabled");
   terr_err_a: assert property (pins.over_temp [*5] |-> error_out_n.oe)
      else $error("overtemperature not on error pin");
   mask_open_a: assert property ((!pins.over_temp && pins.output_disable && !pins.mode_dc) [*5]
      |-> !error_out_n.oe)
      else $error("open flag not masked");
   warn_err_a: assert property ((pins.warn_temp && pins.output_disable && pins.mode_dc) [*5]
      |-> error_out_n.oe)
      else $error("warning not on error pin");
   ser_hold_a: assert property ((!pins.shift_clock && !pins.latch_strobe
      && $stable(pins.mode_dc)) [*6] |=> $stable(serial_out))
      else $error("serial output moved without shift");
   rd_answer_a: assert property ($rose(axi_rsp.rvalid) |-> $past(axi_req.arvalid))
      else $error("read data without request");
   rd_decerr_a: assert property (axi_rsp.rvalid && axi_rsp.rresp != 2'h0
      |-> axi_rsp.rdata == '0)
      else $error("refused read carries data");
endmodule

// ===== tb/serial_ctrl_model.sv
// Behavioural serial controller at the far end of the shift chain.
// Assumes mclk at 20 MHz; the shift clock runs only inside frames, 400 ns period.
`timescale 1ns/1ps

module serial_ctrl_model (
   input  wire logic mclk,
   input  wire logic serial_out,
   output logic      shift_clock,
   output logic      serial_in,
   output logic      latch_strobe
);
   logic [191:0] rx_q;

   initial begin
      shift_clock  = 1'b0;
      serial_in    = 1'b0;
      latch_strobe = 1'b0;
      rx_q         = '0;
   end

   // Returned bits are sampled just before each rise
   task automatic frame(input logic [191:0] data, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge mclk);
         serial_in <= data[i];
         repeat (3) @(posedge mclk);
         shift_clock <= 1'b1;
         rx_q        <= {rx_q[190:0], serial_out};
         repeat (4) @(posedge mclk);
         shift_clock <= 1'b0;
         serial_in   <= ~data[i]; // Hold over: leave no stale level
      end
   endtask

   task automatic latch();
      repeat (4) @(posedge mclk);
      latch_strobe <= 1'b1;
      repeat (4) @(posedge mclk);
      latch_strobe <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
endmodule

// ===== tb/tb_led_sink_serial_and_diag.sv
// Self-checking bench: AXI4-Lite master tasks plus a serial controller model.
// Assumes a 20 MHz mclk and asynchronous active-low resetn.
`timescale 1ns/1ps

module tb_led_sink_serial_and_diag;
   import led_sink_pkg::*;
   logic         mclk = 1'b0;
   logic         resetn = 1'b0;
   axil_req_t    req = '0;
   axil_rsp_t    rsp;
   pins_t        pv = '0;
   pins_t        pins;
   logic         sc, si, ls, sout;
   od_pin_t      err;
   logic [15:0]  chan;
   logic [31:0]  rd;
   logic [191:0] g, b;
   int           errors = 0;
   int           checks_done = 0;

   always #25 mclk = ~mclk;
   assign pins = {sc, si, ls, pv[36:0]};

   led_sink_serial_and_diag dut (.mclk(mclk), .resetn(resetn), .axi_req(req), .axi_rsp(rsp),
      .pins(pins), .serial_out(sout), .error_out_n(err), .sink_channel(chan));
   serial_ctrl_model ctl (.mclk(mclk), .serial_out(sout), .shift_clock(sc),
      .serial_in(si), .latch_strobe(ls));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // Ready is judged on the falling edge, acted on at the next rise
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ha, hw, hb;
      @(posedge mclk);
      req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
      req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1'b1;
      do begin
         @(negedge mclk);
         ha = req.awvalid && rsp.awready;
         hw = req.wvalid && rsp.wready;
         hb = rsp.bvalid;
         r = rsp.bresp;
         @(posedge mclk);
         if (ha) req.awvalid <= 1'b0;
         if (hw) req.wvalid <= 1'b0;
      end while (!hb);
      req.bready <= 1'b0;
   endtask

   task automatic rdreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ha, hr;
      @(posedge mclk);
      req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
      do begin
         @(negedge mclk);
         ha = req.arvalid && rsp.arready;
         hr = rsp.rvalid;
         d = rsp.rdata;
         r = rsp.rresp;
         @(posedge mclk);
         if (ha) req.arvalid <= 1'b0;
      end while (!hr);
      req.rready <= 1'b0;
   endtask

   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge mclk) pv.pwm_count_clock <= 1'b1;
         repeat (4) @(posedge mclk);
         pv.pwm_count_clock <= 1'b0;
         repeat (4) @(posedge mclk);
      end
   endtask

   task automatic finish_test();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      finish_test();
   end

   initial begin
      logic [1:0] rr;
      pv.output_disable <= 1'b1;
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      rdreg(8'h00, rd, rr); chk(rd, 32'h1); chk(rr, 2'h0);
      rdreg(8'h08, rd, rr); chk(rd[18], 1'b0);
      wr(8'h0c, 32'h3, rr); chk(rr, 2'h3);
      rdreg(8'h0c, rd, rr); chk(rr, 2'h3); chk(rd, 32'h0);
      rdreg(8'h00, rd, rr); chk(rd, 32'h1);
      @(posedge mclk) pv.mode_dc <= 1'b1;
      repeat (10) @(posedge mclk);
      g = {96'h0, {3{32'hc3a5_0f1e}}};
      b = {96'h0, {3{32'h5a3c_96e1}}};
      ctl.frame(g, 96);
      ctl.frame(b, 96);
      chk(ctl.rx_q[95:64], g[95:64]); chk(ctl.rx_q[31:0], g[31:0]);
      // First frame returned the power-up contents of the register
      chk(ctl.rx_q[191:160], 32'h0); chk(ctl.rx_q[127:96], 32'h0);
      ctl.latch();
      @(posedge mclk) pv.mode_dc <= 1'b0;
      repeat (10) @(posedge mclk);
      for (int i = 0; i < 16; i++) g[i*12 +: 12] = 12'(i);
      ctl.frame(g, 192);
      ctl.latch();
      @(posedge mclk) begin
         pv.output_disable <= 1'b0;
         pv.open_cmp <= 16'h0010;
         pv.short_cmp <= 16'h0020;
      end
      repeat (10) @(posedge mclk);
      pulse(3);
      repeat (60) @(posedge mclk);
      chk(chan, 16'hfff0);
      rdreg(8'h04, rd, rr); chk(rd, 32'h0020_0010);
      chk(err.oe, 1'b1);
      // Software disable bit acts like the pin on channels and counter
      wr(8'h00, 32'h3, rr); chk(rr, 2'h0);
      chk(chan, 16'h0);
      rdreg(8'h08, rd, rr); chk(rd[11:0], 12'h0);
      rdreg(8'h00, rd, rr); chk(rd, 32'h3);
      wr(8'h00, 32'h1, rr); chk(rr, 2'h0);
      // Run the counter up again so the pin clear below is visible
      pulse(2);
      @(posedge mclk) pv.output_disable <= 1'b1;
      repeat (10) @(posedge mclk);
      chk(chan, 16'h0);
      chk(err.oe, 1'b0);
      rdreg(8'h08, rd, rr); chk(rd[11:0], 12'h0);
      @(posedge mclk) begin
         pv.over_temp <= 1'b1;
         pv.warn_temp <= 1'b1;
      end
      repeat (10) @(posedge mclk);
      chk(err.oe, 1'b1);
      ctl.latch();
      ctl.frame('0, 192);
      chk(ctl.rx_q[175:174], 2'b11);
      chk(ctl.rx_q[167:136], b[95:64]); chk(ctl.rx_q[103:72], b[31:0]);
      chk(ctl.rx_q[191:176], 16'h0010); chk(ctl.rx_q[31:16], 16'h0010);
      chk(ctl.rx_q[15:0], 16'h0020);
      @(posedge mclk) begin
         pv.over_temp <= 1'b0;
         pv.mode_dc <= 1'b1;
      end
      repeat (10) @(posedge mclk);
      chk(err.oe, 1'b1);
      finish_test();
   end
endmodule

bind led_sink_serial_and_diag led_sink_sva #(.N_CH(N_CH)) sva_i (.mclk(mclk), .resetn(resetn),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .pins(pins), .serial_out(serial_out),
   .error_out_n(error_out_n), .sink_channel(sink_channel));
